// file: shared/afmt_pkg.sv
// package for the flash converter output code formatter
// assumes one 50 MHz core clock and static format straps
package afmt_pkg;

    localparam int unsigned CODE_W     = 8;
    localparam int unsigned LOW_W      = 7;
    localparam int unsigned MSB_POS    = 7;
    localparam logic [7:0]  STEP_FIRST = 8'h00;
    localparam logic [7:0]  STEP_LAST  = 8'hff;
    localparam logic [7:0]  CODE_RST   = 8'h00;
    localparam logic [6:0]  LOW_ONES   = 7'h7f;
    localparam logic [2:0]  SYNC_RST   = 3'h7;
    localparam logic [1:0]  FMT_RST    = 2'h3;

    // one converted sample with its strobe
    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } afmt_word_t;

    // static format straps, active low inversion controls
    typedef struct packed {
        logic msb_invert_n;
        logic lsb_invert_n;
    } afmt_fmt_t;

endpackage

// file: src/afmt_core.sv
// output code formatter of an 8-bit flash converter
// assumes the step number comes from the encoder on the core clock
// and the two format straps come from pins outside the clock domain
//
// Notes on behaviour
// - 256 steps, 0 to 255, 8-bit word
// - step 0 at most positive input
// - step rises as input falls, to 255
// - msb_invert_n low inverts the top bit
// - lsb_invert_n low inverts seven lower bits
`timescale 1ns/100ps

module afmt_core (
    // clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  rstn_i,
    // step number from the encoder
    input  wire logic                  step_valid_i,
    input  wire logic [7:0]            step_i,
    // format straps from pins
    input  wire logic                  msb_invert_n_i,
    input  wire logic                  lsb_invert_n_i,
    // formatted output word
    output afmt_pkg::afmt_word_t       word_o
);

    ////////////////////////////////////////////////////////////////////////
    // strap synchronisers, three stages, change taken when 2nd and 3rd agree

    logic [2:0]          msb_sync;
    logic [2:0]          lsb_sync;
    afmt_pkg::afmt_fmt_t fmt;
    logic [7:0]          next_code;

    // stages reset to the true binary level, so release shows no false change
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            msb_sync <= afmt_pkg::SYNC_RST;
        end else begin
            msb_sync <= {msb_sync[1:0], msb_invert_n_i};
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lsb_sync <= afmt_pkg::SYNC_RST;
        end else begin
            lsb_sync <= {lsb_sync[1:0], lsb_invert_n_i};
        end
    end

    // straps default to true binary until the first settled sample
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fmt <= afmt_pkg::FMT_RST;
        end else begin
            if (msb_sync[2] == msb_sync[1]) begin
                fmt.msb_invert_n <= msb_sync[2];
            end
            if (lsb_sync[2] == lsb_sync[1]) begin
                fmt.lsb_invert_n <= lsb_sync[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // formatting

    // step 0 is the top of the range, 255 the bottom; straight binary when both straps are high
    function automatic logic [7:0] afmt_format(input logic [7:0] step,
                                               input afmt_pkg::afmt_fmt_t f);
        logic [afmt_pkg::CODE_W-1:0] res;
        logic                        top_flip;
        logic [afmt_pkg::LOW_W-1:0]  low_flip;
        top_flip = ~f.msb_invert_n;
        low_flip = f.lsb_invert_n ? 7'h00 : afmt_pkg::LOW_ONES;
        res = step;
        res[afmt_pkg::MSB_POS] = step[afmt_pkg::MSB_POS] ^ top_flip;
        res[afmt_pkg::LOW_W-1:0] = step[afmt_pkg::LOW_W-1:0] ^ low_flip;
        return res;
    endfunction

    always_comb begin
        next_code = afmt_format(step_i, fmt);
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            word_o.valid <= 1'b0;
            word_o.code  <= afmt_pkg::CODE_RST;
        end else begin
            word_o.valid <= step_valid_i;
            if (step_valid_i) begin
                word_o.code <= next_code;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    chk_msb_format: assert property (step_valid_i |=>
        word_o.code[7] == ($past(step_i[7]) ^ ~$past(fmt.msb_invert_n)))
        else $error("msb format wrong");

    chk_low_format: assert property (step_valid_i && fmt.lsb_invert_n |=>
        word_o.code[6:0] == $past(step_i[6:0]))
        else $error("true low bits wrong");

    chk_low_invert: assert property (step_valid_i && !fmt.lsb_invert_n |=>
        word_o.code[6:0] == ~$past(step_i[6:0]))
        else $error("inverted low bits wrong");

    chk_step_zero: assert property (step_valid_i && step_i == afmt_pkg::STEP_FIRST
        && fmt == 2'b11 |=> word_o.code == afmt_pkg::STEP_FIRST)
        else $error("step zero not all zero");

    chk_step_last: assert property (step_valid_i && step_i == afmt_pkg::STEP_LAST
        && fmt == 2'b11 |=> word_o.code == afmt_pkg::STEP_LAST)
        else $error("step last not all one");

    chk_valid_follow: assert property (step_valid_i |=> word_o.valid)
        else $error("valid lost");

    chk_hold_code: assert property (!step_valid_i |=> $stable(word_o.code))
        else $error("code changed without sample");

    chk_strap_settle: assert property (
        msb_sync[2] == msb_sync[1] |=> fmt.msb_invert_n == $past(msb_sync[2]))
        else $error("strap not taken");

    // output strobe follows the sample strobe alone
    chk_valid_drop: assert property (!step_valid_i |=> !word_o.valid)
        else $error("valid without sample");

    chk_msb_true: assert property (
        step_valid_i && fmt.msb_invert_n |=> word_o.code[7] == $past(step_i[7]))
        else $error("true top bit wrong");

    chk_msb_invert: assert property (
        step_valid_i && !fmt.msb_invert_n |=> word_o.code[7] != $past(step_i[7]))
        else $error("inverted top bit wrong");

    // corner and mid codes of the inverted, offset and inverted offset formats
    chk_inv_zero: assert property (
        step_valid_i && step_i == afmt_pkg::STEP_FIRST && fmt == 2'b00 |=> word_o.code == 8'hff)
        else $error("inverted step zero wrong");

    chk_inv_last: assert property (
        step_valid_i && step_i == afmt_pkg::STEP_LAST && fmt == 2'b00 |=> word_o.code == 8'h00)
        else $error("inverted step last wrong");

    chk_offset_zero: assert property (
        step_valid_i && step_i == afmt_pkg::STEP_FIRST && fmt == 2'b01 |=> word_o.code == 8'h80)
        else $error("offset step zero wrong");

    chk_offset_last: assert property (
        step_valid_i && step_i == afmt_pkg::STEP_LAST && fmt == 2'b01 |=> word_o.code == 8'h7f)
        else $error("offset step last wrong");

    chk_offset_inv_zero: assert property (
        step_valid_i && step_i == afmt_pkg::STEP_FIRST && fmt == 2'b10 |=> word_o.code == 8'h7f)
        else $error("inverted offset step zero wrong");

    chk_offset_inv_last: assert property (
        step_valid_i && step_i == afmt_pkg::STEP_LAST && fmt == 2'b10 |=> word_o.code == 8'h80)
        else $error("inverted offset step last wrong");

    chk_offset_mid: assert property (
        step_valid_i && step_i == 8'h80 && fmt == 2'b01 |=> word_o.code == 8'h00)
        else $error("offset mid code wrong");

    chk_offset_top: assert property (
        step_valid_i && step_i == 8'h7f && fmt == 2'b01 |=> word_o.code == 8'hff)
        else $error("offset top code wrong");

    chk_offset_inv_mid: assert property (
        step_valid_i && step_i == 8'h80 && fmt == 2'b10 |=> word_o.code == 8'hff)
        else $error("inverted offset mid code wrong");

    chk_inv_mid: assert property (
        step_valid_i && step_i == 8'h7f && fmt == 2'b00 |=> word_o.code == 8'h80)
        else $error("inverted mid code wrong");

    // strap settling and deglitch
    chk_lsb_settle: assert property (
        lsb_sync[2] == lsb_sync[1] |=> fmt.lsb_invert_n == $past(lsb_sync[2]))
        else $error("low strap not taken");

    chk_msb_hold: assert property (
        msb_sync[2] != msb_sync[1] |=> $stable(fmt.msb_invert_n))
        else $error("top strap taken unsettled");

    chk_lsb_hold: assert property (
        lsb_sync[2] != lsb_sync[1] |=> $stable(fmt.lsb_invert_n))
        else $error("low strap taken unsettled");

    chk_msb_deglitch: assert property ($changed(fmt.msb_invert_n) |=> $stable(fmt.msb_invert_n))
        else $error("top strap toggled twice");

    chk_lsb_deglitch: assert property ($changed(fmt.lsb_invert_n) |=> $stable(fmt.lsb_invert_n))
        else $error("low strap toggled twice");

    chk_sync_shift: assert property (
        msb_sync[2:1] == $past(msb_sync[1:0]) && lsb_sync[2:1] == $past(lsb_sync[1:0]))
        else $error("strap synchroniser did not shift");

    chk_fmt_applied: assert property (
        ($stable(msb_invert_n_i) && $stable(lsb_invert_n_i)) [*6] |-> fmt == {msb_invert_n_i, lsb_invert_n_i})
        else $error("steady straps not applied");

    // covers for the four output formats and back to back samples
    cov_true_bin:   cover property (step_valid_i && fmt == 2'b11);
    cov_inv_bin:    cover property (step_valid_i && fmt == 2'b00);
    cov_offset:     cover property (step_valid_i && fmt == 2'b01);
    cov_offset_inv: cover property (step_valid_i && fmt == 2'b10);
    cov_back2back:  cover property (step_valid_i ##1 step_valid_i);

endmodule

// file: test/afmt_sink.sv
// partner model: downstream logic capturing each formatted word
// assumes the formatter output on the same core clock
`timescale 1ns/100ps
module afmt_sink (
    input  wire logic           core_clk_i,
    input  afmt_pkg::afmt_word_t word_i,
    output afmt_pkg::afmt_word_t got_o
);
    always_ff @(posedge core_clk_i) begin
        got_o <= word_i;
    end
endmodule

// file: test/test_flash_adc_output_code_format.sv
// self-checking bench for the output code formatter
// assumes afmt_core, afmt_sink and afmt_pkg compiled first
`timescale 1ns/100ps
module test_flash_adc_output_code_format;
    logic                 core_clk_i = 1'b0;
    logic                 rstn_i = 1'b0;
    logic                 step_valid_i = 1'b0;
    logic [7:0]           step_i = 8'h00;
    logic                 msb_invert_n_i = 1'b1;
    logic                 lsb_invert_n_i = 1'b1;
    afmt_pkg::afmt_word_t word_o;
    afmt_pkg::afmt_word_t got;
    logic [7:0]           exp_q[$];
    logic [7:0]           steps[6] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'hfe, 8'hff};
    int                   bad_count = 0;
    int                   comparisons = 0;
    always #10 core_clk_i = ~core_clk_i;
    afmt_core afmt_core_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .step_valid_i(step_valid_i), .step_i(step_i), .msb_invert_n_i(msb_invert_n_i),
        .lsb_invert_n_i(lsb_invert_n_i), .word_o(word_o));
    afmt_sink afmt_sink_i (.core_clk_i(core_clk_i), .word_i(word_o), .got_o(got));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, want, seen);
        end
    endtask
    // format model: true, inverted, offset and inverted offset codes
    function automatic logic [7:0] expect_code(input logic [7:0] s, input logic [1:0] f);
        case (f)
            2'b11:   return s;
            2'b00:   return ~s;
            2'b01:   return s ^ 8'h80;
            default: return s ^ 8'h7f;
        endcase
    endfunction
    task automatic print_verdict();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic send(input logic [7:0] s);
        @(posedge core_clk_i);
        step_valid_i <= 1'b1;
        step_i <= s;
        exp_q.push_back(expect_code(s, {msb_invert_n_i, lsb_invert_n_i}));
    endtask
    always @(posedge core_clk_i) begin
        if (got.valid === 1'b1) begin
            if (exp_q.size() == 0) check("unexpected word", 8'h01, 8'h00);
            else check("code", got.code, exp_q.pop_front());
        end
    end
    initial begin
        void'($urandom(32'hea41a236));
        for (int m = 0; m < 4; m++) begin
            @(posedge core_clk_i);
            rstn_i <= 1'b0;
            msb_invert_n_i <= m[1];
            lsb_invert_n_i <= m[0];
            repeat (10) @(posedge core_clk_i);
            check("reset code", word_o.code, 8'h00);
            check("reset valid", {7'h00, word_o.valid}, 8'h00);
            rstn_i <= 1'b1;
            repeat (6) @(posedge core_clk_i);
            foreach (steps[i]) send(steps[i]);
            repeat (8) send(8'($urandom()));
            @(posedge core_clk_i);
            step_valid_i <= 1'b0;
            repeat (4) @(posedge core_clk_i);
        end
        for (int t = 0; t < 20 && exp_q.size() != 0; t++) @(posedge core_clk_i);
        if (exp_q.size() != 0) check("pending words", 8'(exp_q.size()), 8'h00);
        print_verdict();
    end
endmodule
